/* File: rtl/acr_pkg.sv */
// constants, state layout and register map of the conversion/read-out block
// assumes a single 25 MHz system clock; times are converted to cycles here
package acr_pkg;
   localparam int unsigned CLK_PERIOD_PS = 40000;
   // conversion time per speed mode, longest time, rounded down
   localparam int unsigned T_CONV_FAST_NS = 750;
   localparam int unsigned T_CONV_NORM_NS = 1000;
   localparam int unsigned T_CONV_LOWP_NS = 1250;
   localparam logic [5:0] CONV_FAST_CYC =
      6'((T_CONV_FAST_NS * 1000) / CLK_PERIOD_PS);
   localparam logic [5:0] CONV_NORM_CYC =
      6'((T_CONV_NORM_NS * 1000) / CLK_PERIOD_PS);
   localparam logic [5:0] CONV_LOWP_CYC =
      6'((T_CONV_LOWP_NS * 1000) / CLK_PERIOD_PS);
   // least spacing of starts, rounded up
   localparam int unsigned T_SPACE_FAST_NS = 1000;
   localparam int unsigned T_SPACE_NORM_NS = 1250;
   localparam int unsigned T_SPACE_LOWP_NS = 1500;
   localparam logic [5:0] SPACE_FAST_CYC =
      6'((T_SPACE_FAST_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
   localparam logic [5:0] SPACE_NORM_CYC =
      6'((T_SPACE_NORM_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
   localparam logic [5:0] SPACE_LOWP_CYC =
      6'((T_SPACE_LOWP_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
   localparam logic [5:0] SPACE_SAT = 6'h3f;
   localparam logic [4:0] SER_LAST_BIT = 5'h0f;
   // register byte addresses
   localparam logic [7:0] REG_CTRL = 8'h00;
   localparam logic [7:0] REG_STATUS = 8'h04;
   localparam logic [7:0] REG_RESULT = 8'h08;
   // control fields
   localparam int unsigned CTRL_SERIAL = 0;
   localparam int unsigned CTRL_READ_AFTER = 1;
   localparam int unsigned CTRL_EXT_CLK = 2;
   localparam int unsigned CTRL_DIV_LO = 3;
   localparam int unsigned CTRL_FAST = 5;
   localparam int unsigned CTRL_LOW_POWER = 6;
   localparam int unsigned CTRL_W = 7;
   localparam logic [6:0] CTRL_RESET = 7'h00;
   // status fields
   localparam int unsigned STAT_BUSY = 0;
   localparam int unsigned STAT_SPACE_ERR = 1;
   localparam int unsigned STAT_SYNC = 2;
   localparam int unsigned STAT_SHIFTING = 3;

   typedef enum logic [1:0] {PH_IDLE, PH_CONV, PH_SHIFT, PH_HOLD} acr_phase_t;

   typedef struct packed {
      logic prev_cnv;
      acr_phase_t phase;
      logic busy;
      logic [5:0] conv_cnt;
      logic [5:0] space_cnt;
      logic space_err;
      logic [15:0] result;
      logic [15:0] data;
      logic data_oe;
      logic sact;
      logic [4:0] bit_cnt;
      logic [3:0] div_cnt;
      logic sclk;
      logic sclk_oe;
      logic sync;
      logic sync_oe;
      logic sdo;
      logic sdo_oe;
      logic [15:0] shreg;
      logic ext_prev;
      logic [CTRL_W-1:0] ctrl;
      logic wr_pend;
      logic [7:0] wr_addr;
      logic [31:0] hrdata;
      logic hresp;
   } acr_state_t;
endpackage : acr_pkg

/* File: rtl/acr_top.sv */
// conversion sequencer and result read-out (parallel, serial master/slave)
// assumes synchronous pins, one AHB-Lite master, hsel gated by the fabric
//
// What this block does
// - Outside serial read-after-convert (master or slave), busy spans one conversion.
// - In parallel mode the result stands on the bus before busy falls.
// - In master read-after-convert, sync rises one conversion after start.
// - In master read-after-convert, busy falls one cycle after sync falls.
// - In master read-during-convert, the serial clock runs at full rate.
// - In master read-after-convert, the divider scales the clock period.
// - In master read-after-convert, busy has a divider-dependent bound.
// - Master serial outputs are driven only while chip select is low.
// - The divider acts only in master read-after-convert, internal clock.
`timescale 1ns/1ps
`default_nettype none
module acr_top (
   input wire logic sys_clk_in,
   input wire logic rst_n_in,
   input wire logic conversion_start_n_in,
   input wire logic chip_select_n_in,
   input wire logic [15:0] sample_in,
   input wire logic serial_clock_in,
   input wire logic hsel_in,
   input wire logic [31:0] haddr_in,
   input wire logic [1:0] htrans_in,
   input wire logic hwrite_in,
   input wire logic [2:0] hsize_in,
   input wire logic [31:0] hwdata_in,
   input wire logic hready_in,
   output logic busy_out,
   output logic [15:0] data_out,
   output logic data_oe_out,
   output logic serial_clock_out,
   output logic serial_clock_oe_out,
   output logic frame_sync_out,
   output logic frame_sync_oe_out,
   output logic serial_data_out,
   output logic serial_data_oe_out,
   output logic [31:0] hrdata_out,
   output logic hreadyout_out,
   output logic hresp_out
);
   acr_pkg::acr_state_t s;
   acr_pkg::acr_state_t next_s;
   logic fall;
   logic serial;
   logic read_after;
   logic ext_clk;
   logic [1:0] serial_clock_divider;
   logic [5:0] conv_cyc;
   logic [5:0] space_cyc;
   logic [3:0] half;
   logic ser_step;
   logic ser_done;
   logic master;

   always_comb begin
      serial = s.ctrl[acr_pkg::CTRL_SERIAL];
      read_after = s.ctrl[acr_pkg::CTRL_READ_AFTER];
      ext_clk = s.ctrl[acr_pkg::CTRL_EXT_CLK];
      serial_clock_divider = s.ctrl[acr_pkg::CTRL_DIV_LO +: 2];
      master = serial & ~ext_clk;
      // speed mode from fast / low-power bits
      case ({s.ctrl[acr_pkg::CTRL_FAST], s.ctrl[acr_pkg::CTRL_LOW_POWER]})
         2'b10: begin
            conv_cyc = acr_pkg::CONV_FAST_CYC;
            space_cyc = acr_pkg::SPACE_FAST_CYC;
         end
         2'b01: begin
            conv_cyc = acr_pkg::CONV_LOWP_CYC;
            space_cyc = acr_pkg::SPACE_LOWP_CYC;
         end
         default: begin
            conv_cyc = acr_pkg::CONV_NORM_CYC;
            space_cyc = acr_pkg::SPACE_NORM_CYC;
         end
      endcase
      // divider only in master read-after-convert
      half = (master & read_after) ? 4'(4'h1 << serial_clock_divider) : 4'h1;
   end

   always_comb begin
      next_s = s;
      fall = s.prev_cnv & ~conversion_start_n_in;
      next_s.prev_cnv = conversion_start_n_in;
      next_s.ext_prev = serial_clock_in;
      next_s.hresp = 1'b0;
      // bus data phase: writes land one cycle after their address phase
      next_s.wr_pend = 1'b0;
      if (s.wr_pend) begin
         case (s.wr_addr)
            acr_pkg::REG_CTRL: next_s.ctrl = hwdata_in[acr_pkg::CTRL_W-1:0];
            acr_pkg::REG_STATUS: begin
               if (hwdata_in[acr_pkg::STAT_SPACE_ERR]) begin
                  next_s.space_err = 1'b0;
               end
            end
            default: ;
         endcase
      end
      if (hsel_in & hready_in & htrans_in[1]) begin
         next_s.wr_pend = hwrite_in;
         next_s.wr_addr = haddr_in[7:0];
         next_s.hrdata = 32'h0;
         if (!hwrite_in) begin
            case (haddr_in[7:0])
               acr_pkg::REG_CTRL: next_s.hrdata = {25'h0, s.ctrl};
               acr_pkg::REG_STATUS: next_s.hrdata = {28'h0, s.sact, s.sync,
                  s.space_err, s.busy};
               acr_pkg::REG_RESULT: next_s.hrdata = {16'h0, s.result};
               default: next_s.hrdata = 32'h0;
            endcase
         end
      end

      if (s.space_cnt != acr_pkg::SPACE_SAT) begin
         next_s.space_cnt = s.space_cnt + 6'h1;
      end

      // serial engine, one bit per falling edge of the internal shift clock or rising edge of the external one
      ser_step = 1'b0;
      ser_done = 1'b0;
      if (s.sact) begin
         if (ext_clk) begin
            ser_step = serial_clock_in & ~s.ext_prev;
         end else if (s.div_cnt == half - 4'h1) begin
            next_s.div_cnt = 4'h0;
            next_s.sclk = ~s.sclk;
            ser_step = s.sclk;
         end else begin
            next_s.div_cnt = s.div_cnt + 4'h1;
         end
         if (ser_step) begin
            next_s.shreg = {s.shreg[14:0], 1'b0};
            next_s.sdo = s.shreg[14];
            next_s.bit_cnt = s.bit_cnt + 5'h1;
            if (s.bit_cnt == acr_pkg::SER_LAST_BIT) begin
               ser_done = 1'b1;
               next_s.sact = 1'b0;
               next_s.sync = 1'b0;
            end
         end
      end

      case (s.phase)
         acr_pkg::PH_IDLE: begin
            if (fall) begin
               if (s.space_cnt >= space_cyc) begin
                  next_s.phase = acr_pkg::PH_CONV;
                  next_s.busy = 1'b1;
                  next_s.conv_cnt = 6'h1;
                  next_s.space_cnt = 6'h0;
                  if (serial & ~read_after & ~s.sact) begin
                     // read-during: previous result shifts out meanwhile
                     next_s.sact = 1'b1;
                     next_s.sync = 1'b1;
                     next_s.shreg = s.result;
                     next_s.sdo = s.result[15];
                     next_s.bit_cnt = 5'h0;
                     next_s.div_cnt = 4'h0;
                     next_s.sclk = 1'b0;
                  end
               end else begin
                  // too-close start is dropped, flagged sticky
                  next_s.space_err = 1'b1;
               end
            end
         end
         acr_pkg::PH_CONV: begin
            next_s.conv_cnt = s.conv_cnt + 6'h1;
            if (s.conv_cnt == conv_cyc - 6'h1) begin
               // one full cycle of margin before busy drops
               next_s.result = sample_in;
               next_s.data = sample_in;
            end
            if (s.conv_cnt == conv_cyc) begin
               if (serial & read_after) begin
                  next_s.phase = acr_pkg::PH_SHIFT;
                  next_s.sact = 1'b1;
                  next_s.sync = 1'b1;
                  next_s.shreg = s.result;
                  next_s.sdo = s.result[15];
                  next_s.bit_cnt = 5'h0;
                  next_s.div_cnt = 4'h0;
                  next_s.sclk = 1'b0;
               end else begin
                  next_s.phase = acr_pkg::PH_IDLE;
                  next_s.busy = 1'b0;
               end
            end
         end
         acr_pkg::PH_SHIFT: begin
            // busy spans conversion, 16 bits at the chosen rate and one PH_HOLD cycle
            if (ser_done) begin
               next_s.phase = acr_pkg::PH_HOLD;
            end
         end
         acr_pkg::PH_HOLD: begin
            next_s.phase = acr_pkg::PH_IDLE;
            next_s.busy = 1'b0;
         end
         default: next_s.phase = acr_pkg::PH_IDLE;
      endcase

      // outputs float one cycle after deselect
      next_s.data_oe = ~serial & ~chip_select_n_in;
      next_s.sync_oe = master & ~chip_select_n_in;
      next_s.sclk_oe = master & ~chip_select_n_in;
      next_s.sdo_oe = serial & ~chip_select_n_in;
      if (ext_clk) begin
         next_s.sclk = 1'b0;
      end
   end

   always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         s <= '{prev_cnv: 1'b1, phase: acr_pkg::PH_IDLE,
                space_cnt: acr_pkg::SPACE_SAT, ctrl: acr_pkg::CTRL_RESET,
                default: '0};
      end else begin
         s <= next_s;
      end
   end

   assign busy_out = s.busy;
   assign data_out = s.data;
   assign data_oe_out = s.data_oe;
   assign serial_clock_out = s.sclk;
   assign serial_clock_oe_out = s.sclk_oe;
   assign frame_sync_out = s.sync;
   assign frame_sync_oe_out = s.sync_oe;
   assign serial_data_out = s.sdo;
   assign serial_data_oe_out = s.sdo_oe;
   assign hrdata_out = s.hrdata;
   assign hreadyout_out = 1'b1;
   assign hresp_out = s.hresp;

   // helper counters for the checks below
   logic [7:0] busy_len;
   logic [7:0] hi_len;
   always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         busy_len <= 8'h0;
         hi_len <= 8'h0;
      end else begin
         busy_len <= s.busy ? busy_len + 8'h1 : 8'h0;
         hi_len <= s.sclk ? hi_len + 8'h1 : 8'h0;
      end
   end

   default clocking cb @(posedge sys_clk_in); endclocking
   default disable iff (!rst_n_in);

   sequence seq_accept;
      s.phase == acr_pkg::PH_IDLE && fall && s.space_cnt >= space_cyc;
   endsequence
   sequence seq_release;
      s.busy ##1 !s.busy;
   endsequence

   a_busy_on_start: assert property (seq_accept |=> s.busy)
      else $error("busy did not rise after start");
   a_busy_width: assert property (s.busy && !(serial && read_after)
      |-> busy_len < 8'(conv_cyc))
      else $error("busy exceeds conversion time");
   a_data_before_busy: assert property ($fell(s.busy) && !serial
      |-> $stable(s.data) && s.data == s.result)
      else $error("parallel data not settled before busy fell");
   a_sync_timing: assert property ($rose(s.sync) && read_after
      |-> busy_len == 8'(conv_cyc))
      else $error("sync rose at wrong time");
   a_busy_after_sync: assert property ($fell(s.sync) && read_after
      && s.phase == acr_pkg::PH_HOLD |-> seq_release)
      else $error("busy release not one cycle after sync");
   a_sclk_fast: assert property ($rose(s.sclk) && !read_after
      |=> !s.sclk)
      else $error("read-during clock not at fastest rate");
   a_div_period: assert property ($fell(s.sclk)
      |-> hi_len == 8'(half))
      else $error("serial clock high time wrong for divider");
   a_cs_float: assert property (chip_select_n_in |=> !s.sync_oe
      && !s.sclk_oe && !s.sdo_oe && !s.data_oe)
      else $error("outputs driven while deselected");
   a_div_ignored: assert property (s.sclk && !(read_after && master)
      |=> !s.sclk)
      else $error("divider applied outside read-after master");
   a_space_err: assert property (s.phase == acr_pkg::PH_IDLE && fall
      && s.space_cnt < space_cyc |=> s.space_err && !s.busy)
      else $error("early start not refused");
endmodule : acr_top
`default_nettype wire

/* File: verif/acr_host_model.sv */
// host-side model: issues conversion strobes, collects serial words
// assumes registered serial outputs of the block on the same clock
`timescale 1ns/1ps
`default_nettype none
module acr_host_model (
   input wire logic clk_in,
   input wire logic rst_n_in,
   input wire logic fire_in,
   input wire logic early_in,
   input wire logic [5:0] gap_in,
   input wire logic sclk_in,
   input wire logic sclk_oe_in,
   input wire logic sync_in,
   input wire logic sync_oe_in,
   input wire logic sdo_in,
   input wire logic sdo_oe_in,
   input wire logic slave_in,
   input wire logic busy_in,
   output logic start_n_out,
   output logic ext_sclk_out,
   output logic [15:0] word_out
);
   logic pend;
   logic [1:0] ext_ph;
   logic [1:0] low_cnt;
   logic [7:0] since;
   logic sclk_q;
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         pend <= 1'b0;
         low_cnt <= 2'h0;
         since <= 8'hff;
         start_n_out <= 1'b1;
         sclk_q <= 1'b0;
         word_out <= 16'h0;
         ext_ph <= 2'h0;
         ext_sclk_out <= 1'b0;
      end else begin
         if (fire_in) begin
            pend <= 1'b1;
         end
         if (since != 8'hff) begin
            since <= since + 8'h01;
         end
         if (low_cnt != 2'h0) begin
            low_cnt <= low_cnt - 2'h1;
            start_n_out <= (low_cnt == 2'h1);
         // pending start waits out the spacing unless early_in is set
         end else if ((pend || fire_in) &&
                      (early_in || since >= {2'h0, gap_in})) begin
            start_n_out <= 1'b0;
            low_cnt <= 2'h2;
            since <= 8'h0;
            pend <= 1'b0;
         end
         sclk_q <= sclk_in;
         // released lines are ignored: only sample while all are driven
         if (sclk_oe_in && sync_oe_in && sdo_oe_in && sync_in &&
             sclk_in && !sclk_q) begin
            word_out <= {word_out[14:0], sdo_in};
         end
         // slave clock: one-cycle pulse every 4 cycles, still unless busy
         if (slave_in && busy_in) begin
            ext_ph <= ext_ph + 2'h1;
         end else begin
            ext_ph <= 2'h0;
         end
         ext_sclk_out <= slave_in && busy_in && ext_ph == 2'h1;
         // pulses during conversion give junk; the last 16 are the frame
         if (slave_in && sdo_oe_in && ext_sclk_out) begin
            word_out <= {word_out[14:0], sdo_in};
         end
      end
   end
endmodule : acr_host_model
`default_nettype wire

/* File: verif/tb.sv */
// testbench: drives the block over AHB-Lite and through the host model
// assumes the host model is compiled first and one 25 MHz clock
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin \
   num_errors++; $display("[ERR] %s exp %0h got %0h", n, e, g); end end
module tb;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic fire = 1'b0;
   logic early = 1'b0;
   logic cs_n = 1'b0;
   logic [5:0] gap = 6'h0;
   logic [15:0] sample = 16'h0;
   logic hsel = 1'b0;
   logic [1:0] htrans = 2'h0;
   logic hwrite = 1'b0;
   logic [31:0] haddr = 32'h0;
   logic [31:0] hwdata = 32'h0;
   logic [31:0] hrdata;
   logic hrdy;
   logic slave = 1'b0;
   logic ext_sclk, hresp, data_oe;
   logic busy, sclk, sclk_oe, sync, sync_oe, sdo, sdo_oe, start_n;
   logic [15:0] data, word;
   int num_errors = 0;
   int check_count = 0;
   logic [31:0] r;
   logic [15:0] cyc = 16'h0, t_st, t_sr, t_sf, t_bf, d_prev, d_fall;
   logic [15:0] b_run = 16'h0, b_len = 16'h0, c_run = 16'h0, c_len;
   logic st_q = 1'b1, sy_q = 1'b0, bz_q = 1'b0, ck_q = 1'b0;
   logic [1:0] cs_q = 2'h0;
   logic float_err = 1'b0;
   logic [5:0] n_cyc [3];
   logic [5:0] n_gap [3];
   logic [31:0] mode [3];

   always #20 clk = ~clk;

   acr_top acr_top_inst (.sys_clk_in(clk), .rst_n_in(rst_n),
      .conversion_start_n_in(start_n), .chip_select_n_in(cs_n),
      .sample_in(sample), .serial_clock_in(ext_sclk), .hsel_in(hsel),
      .haddr_in(haddr), .htrans_in(htrans), .hwrite_in(hwrite),
      .hsize_in(3'h2), .hwdata_in(hwdata), .hready_in(hrdy),
      .busy_out(busy), .data_out(data), .data_oe_out(data_oe),
      .serial_clock_out(sclk), .serial_clock_oe_out(sclk_oe),
      .frame_sync_out(sync), .frame_sync_oe_out(sync_oe),
      .serial_data_out(sdo), .serial_data_oe_out(sdo_oe),
      .hrdata_out(hrdata), .hreadyout_out(hrdy), .hresp_out(hresp));

   acr_host_model acr_host_model_inst (.clk_in(clk), .rst_n_in(rst_n),
      .fire_in(fire), .early_in(early), .gap_in(gap), .sclk_in(sclk),
      .sclk_oe_in(sclk_oe), .sync_in(sync), .sync_oe_in(sync_oe),
      .sdo_in(sdo), .sdo_oe_in(sdo_oe), .slave_in(slave), .busy_in(busy),
      .start_n_out(start_n), .ext_sclk_out(ext_sclk), .word_out(word));

   // edge stamps and run lengths, all from values seen at the edge
   always @(posedge clk) begin
      cyc <= cyc + 16'h1;
      st_q <= start_n;
      sy_q <= sync;
      bz_q <= busy;
      ck_q <= sclk;
      d_prev <= data;
      cs_q <= {cs_q[0], cs_n};
      if (st_q && !start_n) t_st <= cyc;
      if (!sy_q && sync) t_sr <= cyc;
      if (sy_q && !sync) t_sf <= cyc;
      if (bz_q && !busy) begin
         t_bf <= cyc;
         b_len <= b_run;
         d_fall <= d_prev;
      end
      b_run <= busy ? b_run + 16'h1 : 16'h0;
      if (ck_q && !sclk) c_len <= c_run;
      c_run <= sclk ? c_run + 16'h1 : 16'h0;
      if (cs_q == 2'b11 && (sclk_oe || sync_oe || sdo_oe || data_oe)) begin
         float_err <= 1'b1;
      end
   end

   task automatic bus(input logic w, input logic [7:0] a,
                      input logic [31:0] d, output logic [31:0] rd);
      @(posedge clk);
      hsel <= 1'b1;
      htrans <= 2'h2;
      hwrite <= w;
      haddr <= {24'h0, a};
      do @(posedge clk); while (hrdy !== 1'b1);
      htrans <= 2'h0;
      hsel <= 1'b0;
      hwdata <= d;
      do @(posedge clk); while (hrdy !== 1'b1);
      rd = hrdata;
   endtask : bus

   task automatic conv(input logic [31:0] c, input logic [15:0] s,
                       input logic [5:0] g);
      int k;
      logic [31:0] rd;
      bus(1'b1, acr_pkg::REG_CTRL, c, rd);
      sample <= s;
      gap <= g;
      fire <= 1'b1;
      @(posedge clk);
      fire <= 1'b0;
      k = 0;
      while (busy !== 1'b1 && k < 200) begin @(posedge clk); k++; end
      while (busy !== 1'b0 && k < 2000) begin @(posedge clk); k++; end
      `CHK("busy ends", 1'b1, k < 2000)
      @(posedge clk);
   endtask : conv

   task automatic close_out;
      if (num_errors == 0 && check_count > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask : close_out

   initial begin
      #2000000;
      num_errors++;
      close_out();
   end

   initial begin
      n_cyc = '{acr_pkg::CONV_FAST_CYC, acr_pkg::CONV_NORM_CYC,
                acr_pkg::CONV_LOWP_CYC};
      n_gap = '{acr_pkg::SPACE_FAST_CYC, acr_pkg::SPACE_NORM_CYC,
                acr_pkg::SPACE_LOWP_CYC};
      mode = '{32'h20, 32'h0, 32'h40};
      repeat (6) @(posedge clk);
      rst_n <= 1'b1;
      bus(1'b0, acr_pkg::REG_CTRL, 32'h0, r);
      `CHK("ctrl reset", 32'h0, r)
      bus(1'b1, acr_pkg::REG_CTRL, 32'h7f, r);
      bus(1'b0, acr_pkg::REG_CTRL, 32'h0, r);
      `CHK("ctrl rw", 32'h7f, r)
      bus(1'b0, 8'h0c, 32'h0, r);
      `CHK("unmapped", 32'h0, r)
      `CHK("okay resp", 1'b0, hresp)
      for (int i = 0; i < 3; i++) begin
         conv(mode[i], 16'hc35a ^ 16'(i), n_gap[i]);
         `CHK("busy width", 16'(n_cyc[i]), b_len)
         `CHK("data before busy", 16'hc35a ^ 16'(i), d_fall)
         `CHK("data drive", 1'b1, data_oe)
         bus(1'b0, acr_pkg::REG_RESULT, 32'h0, r);
         `CHK("result", {16'h0, 16'hc35a ^ 16'(i)}, r)
      end
      // early start lands after busy drops but inside the spacing
      conv(32'h0, 16'h0f0f, acr_pkg::SPACE_NORM_CYC);
      early <= 1'b1;
      fire <= 1'b1;
      @(posedge clk);
      fire <= 1'b0;
      early <= 1'b0;
      repeat (4) @(posedge clk);
      `CHK("early dropped", 1'b0, busy)
      bus(1'b0, acr_pkg::REG_STATUS, 32'h0, r);
      `CHK("space flag", 32'h2, r)
      bus(1'b1, acr_pkg::REG_STATUS, 32'h2, r);
      bus(1'b0, acr_pkg::REG_STATUS, 32'h0, r);
      `CHK("space clear", 32'h0, r)
      for (int d = 0; d < 4; d++) begin
         conv(32'h3 | 32'(d << 3), 16'h9c31 + 16'(d), acr_pkg::SPACE_NORM_CYC);
         `CHK("serial word", 16'h9c31 + 16'(d), word)
         `CHK("data float", 1'b0, data_oe)
         `CHK("sclk half", 16'(1 << d), c_len)
         `CHK("sync delay", 1'b1, t_sr - t_st >= 16'd24 &&
              t_sr - t_st <= 16'd27)
         `CHK("sync to busy", 16'h1, t_bf - t_sf)
         `CHK("busy bound", 1'b1, b_len <= 16'd29 + 16'(32 << d))
      end
      conv(32'h19, 16'h4bd2, acr_pkg::SPACE_NORM_CYC);
      bus(1'b0, acr_pkg::REG_STATUS, 32'h0, r);
      `CHK("status shifting", 32'hc, r)
      repeat (20) @(posedge clk);
      conv(32'h19, 16'h2d71, acr_pkg::SPACE_NORM_CYC);
      repeat (20) @(posedge clk);
      `CHK("during word", 16'h4bd2, word)
      `CHK("during sclk", 16'h1, c_len)
      `CHK("during busy", 16'(acr_pkg::CONV_NORM_CYC), b_len)
      // slave read-after with divider bits set: divider must not matter
      slave <= 1'b1;
      conv(32'h1f, 16'h5a3c, acr_pkg::SPACE_NORM_CYC);
      slave <= 1'b0;
      `CHK("slave word", 16'h5a3c, word)
      `CHK("slave sclk float", 1'b0, sclk_oe)
      cs_n <= 1'b1;
      conv(32'h3, 16'h1234, acr_pkg::SPACE_NORM_CYC);
      `CHK("float on deselect", 1'b0, float_err)
      close_out();
   end
endmodule : tb
`default_nettype wire
